// >>> core/hsm_monitor.sv
// hot swap supervision and power monitor, apb register slave
// assumes: comparator pins asynchronous, adc logic on pclk
//
// Contract
// - undervoltage flags and forces gate off
// - overvoltage flags and forces gate off
// - power-up needs enable and supply in window
// - low enable holds off, uv still monitored
// - power good low below foldback threshold
// - hysteresis current on above, off below
// - fast overcurrent turns gate off quickly
// - fet bad: held off, sense, gate low
// - second alert follows fet bad by default
// - voltage from sense or output input
// - low or high voltage range selectable
// - average over two to the N samples
// - current results are signed
// - single shot publishes one averaged pair
// - continuous mode publishes latest sample
// - convert only acts in single-shot mode
// - deferred convert starts at bus stop
// - power is input voltage times current per pair, whatever the voltage select
// - accumulate energy, count rollovers and samples
// - energy read captures count coherently
// - peaks kept until cleared by write
// - latched fault cleared by uv or on toggle
//
// The implementer's own choices: the register offsets and the APB slave port.
`default_nettype none
module hsm_monitor
   import hsm_pkg::*;
(
   // clock, reset, enable
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic pready,
   output logic pslverr,
   output logic [31:0] prdata,
   // comparator and bus pins, asynchronous
   input wire logic supply_low_input,
   input wire logic supply_high_input,
   input wire logic enable_input,
   input wire logic foldback_input,
   input wire logic foldback_low_input,
   input wire logic fast_oc_input,
   input wire logic sense_high_input,
   input wire logic gate_low_input,
   input wire logic timer_fault_input,
   input wire logic timer_decayed_input,
   input wire logic scl_input,
   input wire logic sda_input,
   // converter, same clock
   output logic adc_start,
   output logic adc_range_high,
   input wire logic adc_done,
   input wire logic [11:0] adc_vin,
   input wire logic [11:0] adc_output_voltage_input,
   input wire logic signed [11:0] adc_cur,
   // supervision outputs
   output logic gate_enable_out,
   output logic power_good_out_oe,
   output logic hyst_current_en,
   output logic second_alert_output
);
   localparam int OC_BOUND = `HSM_FAST_OC_CYC;

   hsm_state_type r;
   hsm_state_type n;
   hsm_pins_type pins;
   logic stop_seen;
   logic go;
   logic op_rise;
   logic hit;
   logic [31:0] rd;
   logic [11:0] v;
   logic signed [24:0] prod;
   logic [22:0] pos;
   logic [24:0] acc_sum;
   logic [18:0] nsv;
   logic signed [18:0] nsi;
   logic [7:0] last;

   assign pins = '{uv: supply_low_input, ov: supply_high_input,
                   en: enable_input, fb_hi: foldback_input,
                   fb_lo: foldback_low_input, oc: fast_oc_input,
                   sns: sense_high_input, gneg: gate_low_input,
                   tflt: timer_fault_input, tdec: timer_decayed_input,
                   scl: scl_input, sda: sda_input};

   // ****************************************
   // read mux
   // ****************************************
   always_comb
   begin
      hit = 1'b1;
      rd = 32'h0;
      unique case (paddr)
         `HSM_OFF_CONFIG:
            rd = {23'h0, r.cfg.alert_en, 1'b0, r.cfg.avg, 1'b0,
                  r.cfg.rng, r.cfg.vsel, r.cfg.cont};
         `HSM_OFF_CONTROL:
            rd = {29'h0, r.op_on, r.pend, 1'b0};
         `HSM_OFF_STATUS:
            rd = {23'h0, r.st == HSM_CONV, r.pend, r.fault, r.fet_bad,
                  r.oc_flag, ~r.pg_oe, r.gate_on, r.s2.ov, r.s2.uv};
         `HSM_OFF_VOLT:
            rd = {20'h0, r.volt};
         `HSM_OFF_CUR:
            rd = {{20{r.cur[11]}}, r.cur};
         `HSM_OFF_POWER:
            rd = {{8{r.pin[23]}}, r.pin};
         `HSM_OFF_ENERGY:
            rd = {r.roll, r.acc};
         `HSM_OFF_ESAMP:
            rd = {8'h0, r.samp_sh};
         `HSM_OFF_PK_I:
            rd = {{20{r.peak_i[11]}}, r.peak_i};
         `HSM_OFF_PK_VIN:
            rd = {20'h0, r.peak_input_voltage_read};
         `HSM_OFF_PK_OUTPUT_VOLTAGE_INPUT:
            rd = {20'h0, r.peak_output_voltage_read};
         default:
            hit = 1'b0;
      endcase
   end

   // ****************************************
   // next state
   // ****************************************
   always_comb
   begin
      n = r;
      go = 1'b0;
      op_rise = 1'b0;
      v = 12'h0;
      prod = 25'sh0;
      pos = 23'h0;
      acc_sum = 25'h0;
      nsv = 19'h0;
      nsi = 19'sh0;
      last = 8'h0;
      // only stage two reads stage one
      n.s1 = pins;
      n.s2 = r.s1;
      n.sda_d = r.s2.sda;
      n.uv_d = r.s2.uv;
      n.adc_start = 1'b0;
      n.pready = 1'b0;
      n.pslverr = 1'b0;
      // stop condition: data rises while clock high
      stop_seen = r.s2.scl & r.s2.sda & ~r.sda_d;

      // apb setup cycle: answer in the access cycle
      if (psel && !penable)
      begin
         n.pready = 1'b1;
         n.pslverr = ~hit;
         n.prdata = rd;
         if (!pwrite && paddr == `HSM_OFF_ENERGY)
            n.samp_sh = r.samp;
      end

      // apb writes at the access edge
      if (psel && penable && r.pready && pwrite)
      begin
         unique case (paddr)
            `HSM_OFF_CONFIG:
            begin
               n.cfg.cont = pwdata[`HSM_CFG_CONT];
               n.cfg.vsel = pwdata[`HSM_CFG_VSEL];
               n.cfg.rng = pwdata[`HSM_CFG_RNG];
               n.cfg.avg = pwdata[`HSM_CFG_AVG_LO +: 3];
               n.cfg.alert_en = pwdata[`HSM_CFG_ALERT];
            end
            `HSM_OFF_CONTROL:
            begin
               n.op_on = pwdata[`HSM_CTL_ON];
               op_rise = pwdata[`HSM_CTL_ON] & ~r.op_on;
               // convert ignored in continuous mode
               if (pwdata[`HSM_CTL_CONVERT] && !r.cfg.cont)
               begin
                  if (pwdata[`HSM_CTL_DEFER])
                     n.pend = 1'b1;
                  else
                     go = 1'b1;
               end
            end
            `HSM_OFF_STATUS:
               if (pwdata[`HSM_STS_OC])
                  n.oc_flag = 1'b0;
            `HSM_OFF_PK_I:
               n.peak_i = `HSM_PEAK_I_RST;
            `HSM_OFF_PK_VIN:
               n.peak_input_voltage_read = 12'h0;
            `HSM_OFF_PK_OUTPUT_VOLTAGE_INPUT:
               n.peak_output_voltage_read = 12'h0;
            default:
               n.pend = n.pend;
         endcase
      end

      // group command: all devices start on the stop
      if (r.pend && stop_seen)
      begin
         n.pend = 1'b0;
         go = 1'b1;
      end

      // ****************************************
      // supervision
      // ****************************************
      if (r.s2.tdec && ((r.uv_d && !r.s2.uv) || op_rise))
         n.fault = 1'b0;
      if (r.s2.tflt)
         n.fault = 1'b1;
      if (r.s2.oc)
         n.oc_flag = 1'b1;
      // uv and ov status track the pins regardless of enable
      n.gate_on = r.op_on & r.s2.en & ~r.s2.uv & ~r.s2.ov
                  & ~r.fault & ~r.s2.oc;
      n.pg_oe = ~r.s2.fb_hi;
      if (r.s2.fb_hi)
         n.hyst_en = 1'b1;
      else if (!r.s2.fb_lo)
         n.hyst_en = 1'b0;
      n.fet_bad = ~r.gate_on & r.s2.sns & r.s2.gneg;
      n.alert2 = r.fet_bad & r.cfg.alert_en;

      // ****************************************
      // conversion sequencer
      // ****************************************
      if (r.st == HSM_IDLE && (go || r.cfg.cont))
      begin
         n.st = HSM_CONV;
         n.cnt = 8'h0;
         n.sum_v = 19'h0;
         n.sum_i = 19'sh0;
         n.adc_start = 1'b1;
      end
      else if (r.st == HSM_CONV && adc_done)
      begin
         v = r.cfg.vsel ? adc_output_voltage_input : adc_vin;
         prod = $signed({1'b0, adc_vin}) * adc_cur;
         n.pin = prod[23:0];
         // negative power is not accumulated as energy
         pos = prod[24] ? 23'h0 : prod[22:0];
         acc_sum = {1'b0, r.acc} + {2'b00, pos};
         n.acc = acc_sum[23:0];
         if (acc_sum[24])
            n.roll = r.roll + 8'h1;
         n.samp = r.samp + 24'h1;
         // sample wins over a clear in the same cycle
         if (adc_cur > n.peak_i)
            n.peak_i = adc_cur;
         if (adc_vin > n.peak_input_voltage_read)
            n.peak_input_voltage_read = adc_vin;
         if (adc_output_voltage_input > n.peak_output_voltage_read)
            n.peak_output_voltage_read = adc_output_voltage_input;
         if (r.cfg.cont)
         begin
            n.volt = v;
            n.cur = adc_cur;
            n.adc_start = 1'b1;
         end
         else
         begin
            nsv = r.sum_v + {7'h0, v};
            nsi = r.sum_i + {{7{adc_cur[11]}}, adc_cur};
            n.sum_v = nsv;
            n.sum_i = nsi;
            last = 8'((9'h1 << r.cfg.avg) - 9'h1);
            if (r.cnt == last)
            begin
               n.volt = 12'(nsv >> r.cfg.avg);
               n.cur = 12'(nsi >>> r.cfg.avg);
               n.st = HSM_IDLE;
            end
            else
            begin
               n.cnt = r.cnt + 8'h1;
               n.adc_start = 1'b1;
            end
         end
      end
   end

   // ****************************************
   // state register
   // ****************************************
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         r <= '0;
         r.cfg <= `HSM_CFG_RST;
         r.op_on <= 1'b1;
         r.pg_oe <= 1'b1;
         r.peak_i <= `HSM_PEAK_I_RST;
      end
      else if (ce)
      begin
         r <= n;
      end
   end

   assign pready = r.pready;
   assign pslverr = r.pslverr;
   assign prdata = r.prdata;
   assign adc_start = r.adc_start;
   assign adc_range_high = r.cfg.rng;
   assign gate_enable_out = r.gate_on;
   assign power_good_out_oe = r.pg_oe;
   assign hyst_current_en = r.hyst_en;
   assign second_alert_output = r.alert2;

   // ****************************************
   // checks
   // ****************************************
   a_uv_gate_off: assert property (@(posedge pclk)
      disable iff (!presetn || !ce) r.s2.uv |=> !gate_enable_out)
      else $error("gate on during undervoltage");
   a_ov_gate_off: assert property (@(posedge pclk)
      disable iff (!presetn || !ce) r.s2.ov |=> !gate_enable_out)
      else $error("gate on during overvoltage");
   a_power_up_cond: assert property (@(posedge pclk)
      disable iff (!presetn || !ce) $rose(gate_enable_out) |->
      $past(r.s2.en && !r.s2.uv && !r.s2.ov))
      else $error("power-up without valid window and enable");
   a_enable_holds_off: assert property (@(posedge pclk)
      disable iff (!presetn || !ce) !r.s2.en ##1 !r.s2.en
      |-> !gate_enable_out)
      else $error("gate on while enable low");
   a_pg_follows_fb: assert property (@(posedge pclk)
      disable iff (!presetn || !ce)
      r.s2.fb_hi |=> !power_good_out_oe)
      else $error("power good held low above threshold");
   a_hyst_hold: assert property (@(posedge pclk)
      disable iff (!presetn || !ce)
      hyst_current_en && r.s2.fb_lo |=> hyst_current_en)
      else $error("hysteresis dropped inside band");
   a_fast_oc_off: assert property (@(posedge pclk)
      disable iff (!presetn || !ce)
      $rose(fast_oc_input) ##1 fast_oc_input[*3] |->
      ##[0:OC_BOUND] !gate_enable_out)
      else $error("gate not off after fast overcurrent");
   a_fet_bad_off: assert property (@(posedge pclk)
      disable iff (!presetn || !ce)
      r.fet_bad |-> !$past(gate_enable_out, 1))
      else $error("fet bad while gate driven");
   a_alert_fet: assert property (@(posedge pclk)
      disable iff (!presetn || !ce)
      r.fet_bad && r.cfg.alert_en |=> second_alert_output)
      else $error("second alert missing for bad fet");
   a_sample_count: assert property (@(posedge pclk)
      disable iff (!presetn || !ce)
      r.st == HSM_CONV && adc_done |=> r.samp == $past(r.samp) + 24'h1)
      else $error("sample counter not advanced");
endmodule
`default_nettype wire

// >>> include/hsm_map.svh
// offsets, field positions, reset values and timing of the monitor
// assumes: included by its bare name; guarded against double inclusion
`ifndef HSM_MAP_SVH
`define HSM_MAP_SVH
// ****************************************
// register byte offsets
// ****************************************
`define HSM_OFF_CONFIG 8'h00
`define HSM_OFF_CONTROL 8'h04
`define HSM_OFF_STATUS 8'h08
`define HSM_OFF_VOLT 8'h0c
`define HSM_OFF_CUR 8'h10
`define HSM_OFF_POWER 8'h14
`define HSM_OFF_ENERGY 8'h18
`define HSM_OFF_ESAMP 8'h1c
`define HSM_OFF_PK_I 8'h20
`define HSM_OFF_PK_VIN 8'h24
`define HSM_OFF_PK_OUTPUT_VOLTAGE_INPUT 8'h28
// ****************************************
// field positions
// ****************************************
`define HSM_CFG_CONT 0
`define HSM_CFG_VSEL 1
`define HSM_CFG_RNG 2
`define HSM_CFG_AVG_LO 4
`define HSM_CFG_ALERT 8
`define HSM_CTL_CONVERT 0
`define HSM_CTL_DEFER 1
`define HSM_CTL_ON 2
`define HSM_STS_OC 4
// ****************************************
// reset values and timing
// ****************************************
`define HSM_CFG_RST 7'h01
`define HSM_PEAK_I_RST 12'h800
`define HSM_CLK_MHZ 100
`define HSM_FAST_OC_NS 1000
`define HSM_FAST_OC_CYC ((`HSM_FAST_OC_NS * `HSM_CLK_MHZ) / 1000)
`endif

// >>> include/hsm_pkg.sv
// types shared by the hot swap power monitor
// assumes: hsm_map.svh on the include path
`default_nettype none
package hsm_pkg;
`include "hsm_map.svh"
   typedef struct packed {
      logic uv;
      logic ov;
      logic en;
      logic fb_hi;
      logic fb_lo;
      logic oc;
      logic sns;
      logic gneg;
      logic tflt;
      logic tdec;
      logic scl;
      logic sda;
   } hsm_pins_type;
   typedef enum logic [0:0] {HSM_IDLE = 1'b0, HSM_CONV = 1'b1} hsm_seq_type;
   typedef struct packed {
      logic cont;
      logic vsel;
      logic rng;
      logic [2:0] avg;
      logic alert_en;
   } hsm_cfg_type;
   typedef struct packed {
      hsm_pins_type s1;
      hsm_pins_type s2;
      logic sda_d;
      logic uv_d;
      logic gate_on;
      logic fault;
      logic oc_flag;
      logic pg_oe;
      logic hyst_en;
      logic fet_bad;
      logic alert2;
      hsm_cfg_type cfg;
      logic op_on;
      logic pend;
      hsm_seq_type st;
      logic adc_start;
      logic [7:0] cnt;
      logic [18:0] sum_v;
      logic signed [18:0] sum_i;
      logic [11:0] volt;
      logic signed [11:0] cur;
      logic signed [23:0] pin;
      logic [23:0] acc;
      logic [7:0] roll;
      logic [23:0] samp;
      logic [23:0] samp_sh;
      logic signed [11:0] peak_i;
      logic [11:0] peak_input_voltage_read;
      logic [11:0] peak_output_voltage_read;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } hsm_state_type;
endpackage
`default_nettype wire

// >>> verification/hsm_adc_model.sv
// converter model: answers each start lat+1 cycles after the edge that sees it, with bench values
// assumes: the monitor pulses adc_start for one pclk cycle
`default_nettype none
module hsm_adc_model
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // converter handshake
   input wire logic adc_start,
   output logic adc_done,
   output logic [11:0] adc_vin,
   output logic [11:0] adc_output_voltage_input,
   output logic signed [11:0] adc_cur,
   // bench control
   input wire logic [7:0] lat,
   input wire logic [11:0] vin_val,
   input wire logic [11:0] output_voltage_input_val,
   input wire logic [11:0] cur_val,
   output logic [7:0] starts
);
   logic [7:0] cnt;
   logic busy;
   // ********
   // conversion timing
   // ********
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cnt <= 8'h00;
         busy <= 1'b0;
         adc_done <= 1'b0;
         starts <= 8'h00;
      end
      else
      begin
         adc_done <= 1'b0;
         if (adc_start)
         begin
            busy <= 1'b1;
            cnt <= lat;
            starts <= starts + 8'h01;
         end
         else if (busy && cnt == 8'h00)
         begin
            busy <= 1'b0;
            adc_done <= 1'b1;
         end
         else if (busy)
            cnt <= cnt - 8'h01;
      end
   end
   // ********
   // results
   // ********
   // junk outside the done cycle, so a late sample cannot pass
   assign adc_vin = adc_done ? vin_val : ~vin_val;
   assign adc_output_voltage_input = adc_done ? output_voltage_input_val : ~output_voltage_input_val;
   assign adc_cur = adc_done ? cur_val : ~cur_val;
endmodule
`default_nettype wire

// >>> verification/testbench.sv
// bench of the hot swap monitor: apb host, pins, converter model
// assumes: hsm_pkg, hsm_adc_model and hsm_monitor compiled before
`include "hsm_map.svh"
`default_nettype none
module testbench;
   import hsm_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr;
   logic [7:0] paddr, lat, starts;
   logic [31:0] pwdata, prdata;
   logic uv, ov, en, fb, fb_lo, foc, sns, glow, tflt, tdec, scl, sda;
   logic adc_start, adc_rng, adc_done, gate, pg_oe, hyst, alert;
   logic [11:0] vin, output_voltage_input, vin_val, output_voltage_input_val, cur_val;
   logic signed [11:0] cur;
   int mismatches, comparisons;
   hsm_monitor i_dut (.pclk, .presetn, .ce, .psel, .penable, .pwrite,
      .paddr, .pwdata, .pready, .pslverr, .prdata,
      .supply_low_input(uv), .supply_high_input(ov), .enable_input(en),
      .foldback_input(fb), .foldback_low_input(fb_lo),
      .fast_oc_input(foc), .sense_high_input(sns), .gate_low_input(glow),
      .timer_fault_input(tflt), .timer_decayed_input(tdec),
      .scl_input(scl), .sda_input(sda), .adc_start,
      .adc_range_high(adc_rng), .adc_done, .adc_vin(vin),
      .adc_output_voltage_input(output_voltage_input), .adc_cur(cur), .gate_enable_out(gate),
      .power_good_out_oe(pg_oe), .hyst_current_en(hyst),
      .second_alert_output(alert));
   hsm_adc_model i_adc (.pclk, .presetn, .adc_start, .adc_done,
      .adc_vin(vin), .adc_output_voltage_input(output_voltage_input), .adc_cur(cur), .lat, .vin_val,
      .output_voltage_input_val, .cur_val, .starts);
   initial
   begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   // ********
   // shared tasks
   // ********
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         mismatches++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chkb(input logic got, input logic exp);
      chk({31'h0, got}, {31'h0, exp});
   endtask
   task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] r, output logic e);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (pready !== 1'b1 && n < 50);
      if (pready !== 1'b1)
         mismatches++;
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b1, a, d, r, e);
      chkb(e, 1'b0);
   endtask
   task automatic rdm(input logic [7:0] a, input logic [31:0] m,
      input logic [31:0] x);
      logic [31:0] r;
      logic e;
      apb(1'b0, a, 32'h0, r, e);
      chk(r & m, x);
   endtask
   task automatic wait_gate(input logic x, input int lim);
      int n;
      n = 0;
      while (gate !== x && n < lim)
      begin
         @(posedge pclk);
         n++;
      end
      chkb(gate, x);
   endtask
   // status polling, since the averaging count varies per run
   task automatic wait_busy;
      logic [31:0] r;
      logic e;
      int n;
      n = 0;
      repeat (4) @(posedge pclk);
      do
      begin
         apb(1'b0, `HSM_OFF_STATUS, 32'h0, r, e);
         n++;
      end
      while (r[8] !== 1'b0 && n < 100);
      chkb(r[8], 1'b0);
   endtask
   task automatic done(input string s);
      $display("test %s finished", s);
   endtask
   task automatic finish_test;
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // ********
   // scenarios
   // ********
   task automatic t_reset;
      logic [31:0] r;
      logic e;
      rdm(`HSM_OFF_CONFIG, 32'hffffffff, 32'h100);
      rdm(`HSM_OFF_CONTROL, 32'h6, 32'h4);
      rdm(`HSM_OFF_PK_I, 32'hffffffff, 32'hfffff800);
      apb(1'b0, 8'h2c, 32'h0, r, e);
      chk({r[31:1], e}, 32'h1);
      chkb(pg_oe, 1'b1);
      done("reset");
   endtask
   task automatic t_supervise;
      wait_gate(1'b1, 20);
      uv <= 1'b1;
      wait_gate(1'b0, 20);
      rdm(`HSM_OFF_STATUS, 32'h1, 32'h1);
      {en, uv} <= 2'b00;
      repeat (8) @(posedge pclk);
      chkb(gate, 1'b0);
      uv <= 1'b1;
      repeat (3) @(posedge pclk);
      rdm(`HSM_OFF_STATUS, 32'h1, 32'h1);
      {en, uv} <= 2'b10;
      wait_gate(1'b1, 20);
      ov <= 1'b1;
      wait_gate(1'b0, 20);
      rdm(`HSM_OFF_STATUS, 32'h2, 32'h2);
      ov <= 1'b0;
      wait_gate(1'b1, 20);
      done("supervise");
   endtask
   task automatic t_pgood;
      {fb, fb_lo} <= 2'b11;
      repeat (6) @(posedge pclk);
      chkb(pg_oe, 1'b0);
      chkb(hyst, 1'b1);
      fb <= 1'b0;
      repeat (6) @(posedge pclk);
      chkb(pg_oe, 1'b1);
      chkb(hyst, 1'b1);
      fb_lo <= 1'b0;
      repeat (6) @(posedge pclk);
      chkb(hyst, 1'b0);
      // enable low: pins must not reach the state
      ce <= 1'b0;
      {fb, fb_lo} <= 2'b11;
      repeat (6) @(posedge pclk);
      chkb(pg_oe, 1'b1);
      ce <= 1'b1;
      {fb, fb_lo} <= 2'b00;
      repeat (6) @(posedge pclk);
      chkb(hyst, 1'b0);
      done("power good");
   endtask
   task automatic t_faults;
      foc <= 1'b1;
      wait_gate(1'b0, 100);
      foc <= 1'b0;
      rdm(`HSM_OFF_STATUS, 32'h10, 32'h10);
      wr(`HSM_OFF_STATUS, 32'h10);
      rdm(`HSM_OFF_STATUS, 32'h10, 32'h0);
      wait_gate(1'b1, 20);
      tflt <= 1'b1;
      wait_gate(1'b0, 20);
      {tflt, tdec} <= 2'b01;
      repeat (8) @(posedge pclk);
      chkb(gate, 1'b0);
      rdm(`HSM_OFF_STATUS, 32'h40, 32'h40);
      wr(`HSM_OFF_CONTROL, 32'h0);
      wr(`HSM_OFF_CONTROL, 32'h4);
      wait_gate(1'b1, 20);
      tdec <= 1'b0;
      done("faults");
   endtask
   task automatic t_fet;
      {en, sns, glow} <= 3'b011;
      repeat (8) @(posedge pclk);
      chkb(alert, 1'b1);
      rdm(`HSM_OFF_STATUS, 32'h30, 32'h20);
      wr(`HSM_OFF_CONFIG, 32'h0);
      repeat (3) @(posedge pclk);
      chkb(alert, 1'b0);
      wr(`HSM_OFF_CONFIG, 32'h100);
      repeat (3) @(posedge pclk);
      chkb(alert, 1'b1);
      sns <= 1'b0;
      repeat (6) @(posedge pclk);
      chkb(alert, 1'b0);
      {en, glow} <= 2'b10;
      wait_gate(1'b1, 20);
      done("fet health");
   endtask
   // largest sample values, so four of them roll the accumulator once
   task automatic t_single;
      logic [7:0] s;
      s = starts;
      wr(`HSM_OFF_CONFIG, 32'h120);
      wr(`HSM_OFF_CONTROL, 32'h5);
      wait_busy();
      chk({24'h0, starts - s}, 32'h4);
      rdm(`HSM_OFF_VOLT, 32'hffffffff, 32'hfff);
      rdm(`HSM_OFF_CUR, 32'hffffffff, 32'h7ff);
      rdm(`HSM_OFF_POWER, 32'hffffffff, 32'h7fe801);
      rdm(`HSM_OFF_ENERGY, 32'hffffffff, 32'h01ffa004);
      rdm(`HSM_OFF_ESAMP, 32'hffffffff, 32'h4);
      {vin_val, cur_val} <= {12'h100, 12'hff0};
      wr(`HSM_OFF_CONFIG, 32'h100);
      wr(`HSM_OFF_CONTROL, 32'h5);
      wait_busy();
      rdm(`HSM_OFF_CUR, 32'hffffffff, 32'hfffffff0);
      rdm(`HSM_OFF_POWER, 32'hffffffff, 32'hfffff000);
      rdm(`HSM_OFF_ENERGY, 32'hffffffff, 32'h01ffa004);
      rdm(`HSM_OFF_ESAMP, 32'hffffffff, 32'h5);
      rdm(`HSM_OFF_PK_I, 32'hffffffff, 32'h7ff);
      rdm(`HSM_OFF_PK_VIN, 32'hffffffff, 32'hfff);
      wr(`HSM_OFF_PK_VIN, 32'h0);
      rdm(`HSM_OFF_PK_VIN, 32'hffffffff, 32'h0);
      done("single shot");
   endtask
   // bus frame at the slow link rate; the stop releases the start
   task automatic t_defer;
      logic [7:0] s;
      s = starts;
      wr(`HSM_OFF_CONTROL, 32'h7);
      repeat (10) @(posedge pclk);
      chk({24'h0, starts}, {24'h0, s});
      rdm(`HSM_OFF_CONTROL, 32'h6, 32'h6);
      sda <= 1'b0;
      repeat (8) @(posedge pclk);
      repeat (2)
      begin
         scl <= 1'b0;
         repeat (8) @(posedge pclk);
         scl <= 1'b1;
         repeat (8) @(posedge pclk);
      end
      sda <= 1'b1;
      wait_busy();
      chk({24'h0, starts - s}, 32'h1);
      rdm(`HSM_OFF_CONTROL, 32'h2, 32'h0);
      done("deferred");
   endtask
   task automatic t_cont;
      {lat, output_voltage_input_val} <= {8'h0c, 12'h321};
      wr(`HSM_OFF_CONFIG, 32'h107);
      repeat (60) @(posedge pclk);
      chkb(adc_rng, 1'b1);
      rdm(`HSM_OFF_VOLT, 32'hffffffff, 32'h321);
      output_voltage_input_val <= 12'h456;
      repeat (60) @(posedge pclk);
      rdm(`HSM_OFF_VOLT, 32'hffffffff, 32'h456);
      rdm(`HSM_OFF_PK_OUTPUT_VOLTAGE_INPUT, 32'hffffffff, 32'h456);
      wr(`HSM_OFF_CONFIG, 32'h100);
      repeat (3) @(posedge pclk);
      chkb(adc_rng, 1'b0);
      done("continuous");
   endtask
   // ********
   // main sequence and watchdog
   // ********
   initial
   begin
      {psel, penable, pwrite, uv, ov, fb, fb_lo, foc} = '0;
      {sns, glow, tflt, tdec, presetn} = '0;
      {en, scl, sda, ce} = '1;
      {paddr, pwdata, lat} = {8'h00, 32'h0, 8'h03};
      {vin_val, output_voltage_input_val, cur_val} = {12'hfff, 12'h123, 12'h7ff};
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_supervise();
      t_pgood();
      t_faults();
      t_fet();
      t_single();
      t_defer();
      t_cont();
      finish_test();
   end
   initial
   begin
      #100000;
      mismatches++;
      finish_test();
   end
endmodule
`default_nettype wire
